// file: verilog/tscr_consts.svh
// Offsets, field positions, masks and reset values of the tile status bank
`ifndef TSCR_CONSTS_SVH
`define TSCR_CONSTS_SVH

`define TSCR_REG_VECTOR_BASE 8'h01
`define TSCR_REG_TILE_CTRL 8'h02
`define TSCR_REG_BOOT_STATUS 8'h03
`define TSCR_REG_SECURITY 8'h05
`define TSCR_REG_OSC_CTRL 8'h06
`define TSCR_REG_OSC_COUNT0 8'h07

`define TSCR_VB_WMASK 32'hfffc0000
`define TSCR_CTRL_WMASK 32'h03ffff36
`define TSCR_SEC_WMASK 32'h80005fb1
`define TSCR_OSC_WMASK 32'h00000003

`define TSCR_VB_RESET 32'h00000000
`define TSCR_CTRL_RESET 32'h00000000
`define TSCR_SEC_RESET 32'h00000000
`define TSCR_OSC_RESET 32'h00000000

`define TSCR_STRAP_SETTLE 2'h3

`define TSCR_VEC_HI 31
`define TSCR_VEC_LO 16
`define TSCR_CTRL_DELAY_HI 25
`define TSCR_CTRL_DELAY_LO 18
`define TSCR_CTRL_DIV_HI 17
`define TSCR_CTRL_DIV_LO 9
`define TSCR_CTRL_RGMII_EN 8
`define TSCR_CTRL_DIV_DYN 5
`define TSCR_CTRL_DIV_EN 4
`define TSCR_CTRL_UTMI_SEL 2
`define TSCR_CTRL_ULPI_EN 1

`define TSCR_SEC_LOCK 31
`define TSCR_SEC_GDBG_OFF 14
`define TSCR_SEC_OTP_ALL_LOCK 12
`define TSCR_SEC_SECT_HI 11
`define TSCR_SEC_SECT_LO 8
`define TSCR_SEC_OTP_REDUN 7
`define TSCR_SEC_OTP_BOOT 5
`define TSCR_SEC_PLL_JTAG_OFF 4
`define TSCR_SEC_TAP_OFF 0

`define TSCR_OSC_CORE_RUN 1
`define TSCR_OSC_PERIPH_RUN 0

`endif

// file: verilog/tscr_pkg.sv
// Types shared by the tile status register bank
package tscr_pkg;
    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] regnum;
        logic [31:0] wdata;
    } tscr_ps_req_s;

    typedef struct packed {
        logic [7:0] proc_num;
        logic boot_override;
        logic second_core_powered;
        logic otp_poll_off;
        logic boot_ram;
        logic boot_jtag;
    } tscr_boot_s;

    typedef struct packed {
        logic global_debug_off;
        logic otp_all_lock;
        logic [3:0] otp_sector_lock;
        logic otp_redundancy;
        logic otp_boot;
        logic pll_jtag_off;
        logic tap_off;
    } tscr_sec_s;

    typedef enum logic [1:0] {
        TSCR_TX_IDLE = 2'b01,
        TSCR_TX_WAIT = 2'b10
    } tscr_tx_state_e;
endpackage

// file: verilog/tscr_txclk_gen.sv
// Transmit clock divider and data launch delay
`timescale 1ns/100ps
module tscr_txclk_gen (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic enable_in,
    input wire logic [8:0] divider_in,
    input wire logic [7:0] delay_in,
    output logic tx_clk_out,
    output logic data_launch_out
);
    import tscr_pkg::*;

    logic [8:0] cnt_ff;
    logic tx_clk_ff;
    logic [7:0] dly_ff;
    logic launch_ff;
    tscr_tx_state_e state_ff;
    logic rise;

    assign rise = enable_in && (cnt_ff == divider_in);

    // Counter wraps on the divider so a period is divider plus one
    always_ff @(posedge mclk_in) begin
        if (rst_in || !enable_in) begin
            cnt_ff <= 9'h000;
        end else if (cnt_ff >= divider_in) begin
            cnt_ff <= 9'h000;
        end else begin
            cnt_ff <= cnt_ff + 9'h001;
        end
    end

    // Rise has priority when both compares hit, as with a zero divider
    always_ff @(posedge mclk_in) begin
        if (rst_in || !enable_in) begin
            tx_clk_ff <= 1'b0;
        end else if (rise) begin
            tx_clk_ff <= 1'b1;
        end else if (cnt_ff == (divider_in >> 1)) begin
            tx_clk_ff <= 1'b0;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in || !enable_in) begin
            state_ff <= TSCR_TX_IDLE;
            dly_ff <= 8'h00;
            launch_ff <= 1'b0;
        end else begin
            launch_ff <= 1'b0;
            case (state_ff)
                TSCR_TX_IDLE: begin
                    if (rise && delay_in == 8'h00) begin
                        launch_ff <= 1'b1;
                    end else if (rise) begin
                        dly_ff <= delay_in - 8'h01;
                        state_ff <= TSCR_TX_WAIT;
                    end
                end
                TSCR_TX_WAIT: begin
                    if (dly_ff == 8'h00) begin
                        launch_ff <= 1'b1;
                        state_ff <= TSCR_TX_IDLE;
                    end else begin
                        dly_ff <= dly_ff - 8'h01;
                    end
                end
                default: begin
                    state_ff <= TSCR_TX_IDLE;
                end
            endcase
        end
    end

    assign tx_clk_out = tx_clk_ff;
    assign data_launch_out = launch_ff;
endmodule

// file: verilog/tscr_osc_counter.sv
// Ring oscillator tick synchronisers and edge counters
`timescale 1ns/100ps
module tscr_osc_counter (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic [3:0] osc_tick_in,
    input wire logic core_osc_run_in,
    input wire logic periph_osc_run_in,
    output logic [3:0][15:0] oscillator_count_value_out
);
    import tscr_pkg::*;

    logic [3:0] sync1_ff;
    logic [3:0] sync2_ff;
    logic [3:0] sync3_ff;
    logic [3:0] run;
    // Power-up value only; reset leaves the counts alone
    logic [3:0][15:0] count_ff = '0;

    // Oscillators 0 and 1 sit in the core, 2 and 3 in the periphery
    assign run = {periph_osc_run_in, periph_osc_run_in, core_osc_run_in, core_osc_run_in};

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            sync1_ff <= 4'h0;
            sync2_ff <= 4'h0;
            sync3_ff <= 4'h0;
        end else begin
            sync1_ff <= osc_tick_in;
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
        end
    end

    // Counts survive reset on purpose; they freeze while the run bits are clear, as after reset
    always_ff @(posedge mclk_in) begin
        for (int i = 0; i < 4; i++) begin
            if (run[i] && sync2_ff[i] && !sync3_ff[i]) begin
                count_ff[i] <= count_ff[i] + 16'h0001;
            end
        end
    end

    assign oscillator_count_value_out = count_ff;
endmodule

// file: verilog/tscr_top.sv
// Tile processor status register bank with its controlled features
// Notes on behaviour
// - handler address is base high, vector low
// - vector base bits 31:18 writable, rest zero
// - tile control 25:18 sets transmit data delay
// - transmit clock rises at divider, falls at half
// - tile control bit 8 enables RGMII
// - dynamic divider acts only when threads paused
// - tile control bit 4 enables low-power divider
// - tile control bit 2 picks UTMI or ULPI
// - tile control bit 1 enables ULPI support
// - boot status read-only, processor number 23:16
// - boot status reports override, power, boot sources, straps
// - security register loaded from OTP word
// - security bit 31 blocks further writes
// - security bits 14, 0 disable debug access
// - security bit 12, bits 11:8 lock OTP
// - security bit 7 enables OTP redundancy
// - security bits 5, 4 secure boot, PLL JTAG
// - four free-running oscillators each clock a counter
// - oscillator control bits 1, 0 enable rings
// - first count read-only, survives reset
`timescale 1ns/100ps
`include "tscr_consts.svh"
module tscr_top (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire tscr_pkg::tscr_ps_req_s ps_req_in,
    input wire logic event_valid_in,
    input wire logic [15:0] event_vector_in,
    input wire logic all_threads_paused_in,
    input wire tscr_pkg::tscr_boot_s boot_in,
    input wire logic [1:0] pll_strap_pins_in,
    input wire logic otp_load_valid_in,
    input wire logic [31:0] otp_security_word_in,
    input wire logic [3:0] osc_tick_in,
    output logic rd_valid_out,
    output logic [31:0] rd_data_out,
    output logic handler_valid_out,
    output logic [31:0] handler_addr_out,
    output logic rgmii_enable_out,
    output logic rgmii_tx_clk_out,
    output logic rgmii_data_launch_out,
    output logic lp_divider_active_out,
    output logic usb_utmi_mode_out,
    output logic ulpi_support_en_out,
    output tscr_pkg::tscr_sec_s security_out,
    output logic core_osc_run_out,
    output logic periph_osc_run_out,
    output logic [3:0][15:0] oscillator_count_value_out
);
    import tscr_pkg::*;

    logic [31:0] vector_base_ff;
    logic [31:0] tile_ctrl_ff;
    logic [31:0] security_ff;
    logic [31:0] osc_ctrl_ff;
    tscr_boot_s boot_ff;
    logic [1:0] pll_strap_value_ff;
    logic boot_taken_ff;
    logic [1:0] strap_s1_ff;
    logic [1:0] strap_s2_ff;
    logic [1:0] strap_s3_ff;
    logic [1:0] strap_age_ff;
    logic rd_valid_ff;
    logic [31:0] rd_data_ff;
    logic handler_valid_ff;
    logic [31:0] handler_addr_ff;
    logic lp_div_ff;
    logic [31:0] nxt_rd_data;
    logic [31:0] boot_word;
    logic wr_req;
    logic rd_req;

    // Masked write keeps read-only bits at zero
    function automatic logic [31:0] masked_write(input logic [31:0] data,
                                                  input logic [31:0] mask);
        masked_write = data & mask;
    endfunction

    function automatic logic hits(input tscr_ps_req_s req, input logic [7:0] num);
        hits = req.valid && (req.regnum == num);
    endfunction

    assign wr_req = ps_req_in.valid && ps_req_in.write;
    assign rd_req = ps_req_in.valid && !ps_req_in.write;

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            vector_base_ff <= `TSCR_VB_RESET;
        end else if (wr_req && hits(ps_req_in, `TSCR_REG_VECTOR_BASE)) begin
            vector_base_ff <= masked_write(ps_req_in.wdata, `TSCR_VB_WMASK);
        end
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            tile_ctrl_ff <= `TSCR_CTRL_RESET;
        end else if (wr_req && hits(ps_req_in, `TSCR_REG_TILE_CTRL)) begin
            tile_ctrl_ff <= masked_write(ps_req_in.wdata, `TSCR_CTRL_WMASK);
        end
    end

    // OTP copy loads regardless of the lock; only software writes are barred
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            security_ff <= `TSCR_SEC_RESET;
        end else if (otp_load_valid_in) begin
            security_ff <= masked_write(otp_security_word_in, `TSCR_SEC_WMASK);
        end else if (wr_req && hits(ps_req_in, `TSCR_REG_SECURITY) &&
                     !security_ff[`TSCR_SEC_LOCK]) begin
            security_ff <= masked_write(ps_req_in.wdata, `TSCR_SEC_WMASK);
        end
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            osc_ctrl_ff <= `TSCR_OSC_RESET;
        end else if (wr_req && hits(ps_req_in, `TSCR_REG_OSC_CTRL)) begin
            osc_ctrl_ff <= masked_write(ps_req_in.wdata, `TSCR_OSC_WMASK);
        end
    end

    // Strap pins are asynchronous; taken once two stages agree after reset
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            strap_s1_ff <= 2'h0;
            strap_s2_ff <= 2'h0;
            strap_s3_ff <= 2'h0;
        end else begin
            strap_s1_ff <= pll_strap_pins_in;
            strap_s2_ff <= strap_s1_ff;
            strap_s3_ff <= strap_s2_ff;
        end
    end

    // Stages still hold reset zeros at first; wait until pin data fills them
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            strap_age_ff <= 2'h0;
        end else if (strap_age_ff != `TSCR_STRAP_SETTLE) begin
            strap_age_ff <= strap_age_ff + 2'h1;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            boot_taken_ff <= 1'b0;
            boot_ff <= '0;
            pll_strap_value_ff <= 2'h0;
        end else if (!boot_taken_ff && strap_age_ff == `TSCR_STRAP_SETTLE &&
                     strap_s2_ff == strap_s3_ff) begin
            boot_taken_ff <= 1'b1;
            boot_ff <= boot_in;
            pll_strap_value_ff <= strap_s3_ff;
        end
    end

    always_comb begin
        boot_word = 32'h00000000;
        boot_word[23:16] = boot_ff.proc_num;
        boot_word[8] = boot_ff.boot_override;
        boot_word[5] = boot_ff.second_core_powered;
        boot_word[4] = boot_ff.otp_poll_off;
        boot_word[3] = boot_ff.boot_ram;
        boot_word[2] = boot_ff.boot_jtag;
        boot_word[1:0] = pll_strap_value_ff;
    end

    // Unmapped numbers read as zero
    always_comb begin
        case (ps_req_in.regnum)
            `TSCR_REG_VECTOR_BASE: nxt_rd_data = vector_base_ff;
            `TSCR_REG_TILE_CTRL: nxt_rd_data = tile_ctrl_ff;
            `TSCR_REG_BOOT_STATUS: nxt_rd_data = boot_word;
            `TSCR_REG_SECURITY: nxt_rd_data = security_ff;
            `TSCR_REG_OSC_CTRL: nxt_rd_data = osc_ctrl_ff;
            `TSCR_REG_OSC_COUNT0: nxt_rd_data = {16'h0000, oscillator_count_value_out[0]};
            default: nxt_rd_data = 32'h00000000;
        endcase
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            rd_valid_ff <= 1'b0;
            rd_data_ff <= 32'h00000000;
        end else begin
            rd_valid_ff <= rd_req;
            if (rd_req) begin
                rd_data_ff <= nxt_rd_data;
            end
        end
    end

    // Bits 17:16 of the base are reserved zeros and pass through; the vector fills bits 15:0
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            handler_valid_ff <= 1'b0;
            handler_addr_ff <= 32'h00000000;
        end else begin
            handler_valid_ff <= event_valid_in;
            if (event_valid_in) begin
                handler_addr_ff <= {vector_base_ff[`TSCR_VEC_HI:`TSCR_VEC_LO],
                                    event_vector_in};
            end
        end
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            lp_div_ff <= 1'b0;
        end else begin
            lp_div_ff <= tile_ctrl_ff[`TSCR_CTRL_DIV_EN] &&
                         (!tile_ctrl_ff[`TSCR_CTRL_DIV_DYN] || all_threads_paused_in);
        end
    end

    tscr_txclk_gen u_txclk (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .enable_in(tile_ctrl_ff[`TSCR_CTRL_RGMII_EN]),
        .divider_in(tile_ctrl_ff[`TSCR_CTRL_DIV_HI:`TSCR_CTRL_DIV_LO]),
        .delay_in(tile_ctrl_ff[`TSCR_CTRL_DELAY_HI:`TSCR_CTRL_DELAY_LO]),
        .tx_clk_out(rgmii_tx_clk_out),
        .data_launch_out(rgmii_data_launch_out)
    );

    tscr_osc_counter u_osc (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .osc_tick_in(osc_tick_in),
        .core_osc_run_in(osc_ctrl_ff[`TSCR_OSC_CORE_RUN]),
        .periph_osc_run_in(osc_ctrl_ff[`TSCR_OSC_PERIPH_RUN]),
        .oscillator_count_value_out(oscillator_count_value_out)
    );

    assign rd_valid_out = rd_valid_ff;
    assign rd_data_out = rd_data_ff;
    assign handler_valid_out = handler_valid_ff;
    assign handler_addr_out = handler_addr_ff;
    assign rgmii_enable_out = tile_ctrl_ff[`TSCR_CTRL_RGMII_EN];
    assign lp_divider_active_out = lp_div_ff;
    assign usb_utmi_mode_out = tile_ctrl_ff[`TSCR_CTRL_UTMI_SEL];
    assign ulpi_support_en_out = tile_ctrl_ff[`TSCR_CTRL_ULPI_EN];
    assign security_out.global_debug_off = security_ff[`TSCR_SEC_GDBG_OFF];
    assign security_out.tap_off = security_ff[`TSCR_SEC_TAP_OFF];
    assign security_out.otp_all_lock = security_ff[`TSCR_SEC_OTP_ALL_LOCK];
    assign security_out.otp_sector_lock = security_ff[`TSCR_SEC_SECT_HI:`TSCR_SEC_SECT_LO];
    assign security_out.otp_redundancy = security_ff[`TSCR_SEC_OTP_REDUN];
    assign security_out.otp_boot = security_ff[`TSCR_SEC_OTP_BOOT];
    assign security_out.pll_jtag_off = security_ff[`TSCR_SEC_PLL_JTAG_OFF];
    assign core_osc_run_out = osc_ctrl_ff[`TSCR_OSC_CORE_RUN];
    assign periph_osc_run_out = osc_ctrl_ff[`TSCR_OSC_PERIPH_RUN];
endmodule

// file: sim/tscr_top_properties.sv
// Port-level assertions for the tile status bank
`timescale 1ns/100ps
`include "tscr_consts.svh"
module tscr_top_properties (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire tscr_pkg::tscr_ps_req_s ps_req_in,
    input wire logic event_valid_in,
    input wire logic [15:0] event_vector_in,
    input wire logic all_threads_paused_in,
    input wire tscr_pkg::tscr_boot_s boot_in,
    input wire logic [1:0] pll_strap_pins_in,
    input wire logic otp_load_valid_in,
    input wire logic [31:0] otp_security_word_in,
    input wire logic [3:0] osc_tick_in,
    input wire logic rd_valid_out,
    input wire logic [31:0] rd_data_out,
    input wire logic handler_valid_out,
    input wire logic [31:0] handler_addr_out,
    input wire logic rgmii_enable_out,
    input wire logic rgmii_tx_clk_out,
    input wire logic rgmii_data_launch_out,
    input wire logic lp_divider_active_out,
    input wire logic usb_utmi_mode_out,
    input wire logic ulpi_support_en_out,
    input wire tscr_pkg::tscr_sec_s security_out,
    input wire logic core_osc_run_out,
    input wire logic periph_osc_run_out,
    input wire logic [3:0][15:0] oscillator_count_value_out
);
    import tscr_pkg::*;
    tscr_ps_req_s req_ff;
    logic [31:0] otp_ff;
    always_ff @(posedge mclk_in) begin
        req_ff <= ps_req_in;
    end
    always_ff @(posedge mclk_in) begin
        otp_ff <= otp_security_word_in;
    end
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (rst_in);

    chk_read_answer: assert property (
        ps_req_in.valid && !ps_req_in.write |=> rd_valid_out ##1 !rd_valid_out || $past(ps_req_in.valid))
        else $error("read answer missing");
    chk_handler_addr: assert property (
        event_valid_in |=> handler_valid_out && handler_addr_out[15:0] == $past(event_vector_in))
        else $error("handler address wrong");
    chk_vector_low: assert property (
        rd_valid_out && req_ff.regnum == `TSCR_REG_VECTOR_BASE |-> rd_data_out[17:0] == 18'h0)
        else $error("vector base low bits set");
    chk_ctrl_reserved: assert property (
        rd_valid_out && req_ff.regnum == `TSCR_REG_TILE_CTRL |-> !(rd_data_out & ~`TSCR_CTRL_WMASK))
        else $error("tile control reserved bits set");
    chk_count_upper: assert property (
        rd_valid_out && req_ff.regnum == `TSCR_REG_OSC_COUNT0 |-> rd_data_out[31:16] == 16'h0)
        else $error("count upper bits set");
    chk_ctrl_outputs: assert property (
        ps_req_in.valid && ps_req_in.write && ps_req_in.regnum == `TSCR_REG_TILE_CTRL |=>
        {rgmii_enable_out, usb_utmi_mode_out, ulpi_support_en_out}
        == {req_ff.wdata[8], req_ff.wdata[2:1]})
        else $error("tile control outputs wrong");
    chk_osc_run: assert property (
        ps_req_in.valid && ps_req_in.write && ps_req_in.regnum == `TSCR_REG_OSC_CTRL |=>
        {core_osc_run_out, periph_osc_run_out} == req_ff.wdata[1:0])
        else $error("oscillator run bits wrong");
    chk_otp_copy: assert property (
        otp_load_valid_in |=> security_out
        == {otp_ff[14], otp_ff[12], otp_ff[11:7], otp_ff[5:4], otp_ff[0]})
        else $error("security copy wrong");
    chk_txclk_idle: assert property (
        !rgmii_enable_out [*2] |-> !rgmii_tx_clk_out)
        else $error("tx clock runs while disabled");
endmodule

bind tscr_top tscr_top_properties i_tscr_top_properties (.mclk_in, .rst_in, .ps_req_in,
    .event_valid_in, .event_vector_in, .all_threads_paused_in, .boot_in, .pll_strap_pins_in,
    .otp_load_valid_in, .otp_security_word_in, .osc_tick_in, .rd_valid_out, .rd_data_out,
    .handler_valid_out, .handler_addr_out, .rgmii_enable_out, .rgmii_tx_clk_out,
    .rgmii_data_launch_out, .lp_divider_active_out, .usb_utmi_mode_out,
    .ulpi_support_en_out, .security_out, .core_osc_run_out, .periph_osc_run_out,
    .oscillator_count_value_out);

// file: sim/tb_top.sv
// Randomised self-checking bench for the tile status bank
`timescale 1ns/100ps
`include "tscr_consts.svh"
module tb_top;
    import tscr_pkg::*;
    logic mclk_in = 1'b0;
    logic rst_in = 1'b1;
    tscr_ps_req_s ps_req_in = '0;
    logic event_valid_in = 1'b0;
    logic [15:0] event_vector_in = 16'h0;
    logic all_threads_paused_in = 1'b0;
    tscr_boot_s boot_in = '0;
    logic [1:0] pll_strap_pins_in = 2'h0;
    logic otp_load_valid_in = 1'b0;
    logic [31:0] otp_security_word_in = 32'h0;
    logic [3:0] osc_tick_in = 4'h0;
    logic rd_valid_out, handler_valid_out, rgmii_enable_out, rgmii_tx_clk_out;
    logic rgmii_data_launch_out, lp_divider_active_out, usb_utmi_mode_out;
    logic ulpi_support_en_out, core_osc_run_out, periph_osc_run_out;
    logic [31:0] rd_data_out, handler_addr_out, w, base;
    tscr_sec_s security_out;
    logic [3:0][15:0] oscillator_count_value_out;
    logic [7:0] rw_regs [4] = '{8'h01, 8'h02, 8'h05, 8'h06};
    int err_total = 0;
    int samples_checked = 0;
    int d, dl;

    tscr_top i_tscr_top (.mclk_in, .rst_in, .ps_req_in, .event_valid_in, .event_vector_in,
        .all_threads_paused_in, .boot_in, .pll_strap_pins_in, .otp_load_valid_in,
        .otp_security_word_in, .osc_tick_in, .rd_valid_out, .rd_data_out, .handler_valid_out,
        .handler_addr_out, .rgmii_enable_out, .rgmii_tx_clk_out, .rgmii_data_launch_out,
        .lp_divider_active_out, .usb_utmi_mode_out, .ulpi_support_en_out, .security_out,
        .core_osc_run_out, .periph_osc_run_out, .oscillator_count_value_out);

    always #12.5 mclk_in = ~mclk_in;

    function automatic logic [31:0] rw_mask(input logic [7:0] num);
        case (num)
            `TSCR_REG_VECTOR_BASE: return `TSCR_VB_WMASK;
            `TSCR_REG_TILE_CTRL: return `TSCR_CTRL_WMASK;
            `TSCR_REG_SECURITY: return `TSCR_SEC_WMASK;
            `TSCR_REG_OSC_CTRL: return `TSCR_OSC_WMASK;
            default: return 32'h0;
        endcase
    endfunction

    function automatic logic [31:0] boot_word();
        return {8'h0, boot_in.proc_num, 7'h0, boot_in.boot_override, 2'h0,
            boot_in.second_core_powered, boot_in.otp_poll_off, boot_in.boot_ram,
            boot_in.boot_jtag, pll_strap_pins_in};
    endfunction

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge mclk_in);
    endtask

    task automatic ps_access(input logic wr, input logic [7:0] num, input logic [31:0] data);
        @(negedge mclk_in);
        ps_req_in <= '{valid: 1'b1, write: wr, regnum: num, wdata: data};
        @(negedge mclk_in);
        ps_req_in <= '0;
    endtask

    task automatic rd_chk(input logic [7:0] num, input logic [31:0] exp, input string name);
        ps_access(1'b0, num, 32'h0);
        check("read valid", 32'h1, {31'h0, rd_valid_out});
        check(name, exp, rd_data_out);
    endtask

    task automatic ticks(input int n);
        repeat (n) begin
            osc_tick_in <= 4'hf;
            cyc(4);
            osc_tick_in <= 4'h0;
            cyc(4);
        end
    endtask

    task automatic tx_check();
        logic [39:0] ck, ln;
        int r1, r2, f, l;
        ps_access(1'b1, `TSCR_REG_TILE_CTRL, 32'(dl << 18) | 32'(d << 9) | 32'h100);
        cyc(2 * d + 4);
        for (int i = 0; i < 40; i++) begin
            @(negedge mclk_in);
            ck[i] = rgmii_tx_clk_out;
            ln[i] = rgmii_data_launch_out;
        end
        r1 = -1;
        r2 = -1;
        f = -1;
        l = -1;
        for (int i = 1; i < 40; i++) begin
            if (ck[i] && !ck[i-1] && r1 >= 0 && r2 < 0) r2 = i;
            if (ck[i] && !ck[i-1] && r1 < 0) r1 = i;
            if (r1 >= 0 && f < 0 && !ck[i] && ck[i-1]) f = i;
            if (r1 >= 0 && l < 0 && ln[i]) l = i;
        end
        check("tx period", d + 1, r2 - r1);
        check("tx high time", (d >> 1) + 1, f - r1);
        check("tx launch delay", dl, l - r1);
    endtask

    task automatic conclude();
        $display("mismatches %0d, comparisons %0d", err_total, samples_checked);
        if (err_total == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Whole run is a few hundred cycles; the 20000-cycle limit leaves a wide margin
    initial begin
        #500000;
        err_total++;
        conclude();
    end

    initial begin
        void'($urandom(68894));
        boot_in = tscr_boot_s'(13'($urandom));
        pll_strap_pins_in = 2'($urandom);
        cyc(5);
        rst_in <= 1'b0;
        cyc(6);
        foreach (rw_regs[i]) rd_chk(rw_regs[i], 32'h0, "reset value");
        rd_chk(`TSCR_REG_BOOT_STATUS, boot_word(), "boot status");
        ps_access(1'b1, `TSCR_REG_BOOT_STATUS, $urandom);
        rd_chk(`TSCR_REG_BOOT_STATUS, boot_word(), "boot after write");
        for (int k = 0; k < 12; k++) begin
            w = (k == 0) ? 32'hffffffff : $urandom;
            ps_access(1'b1, rw_regs[k % 4], w & 32'h7fffffff);
            rd_chk(rw_regs[k % 4], w & 32'h7fffffff & rw_mask(rw_regs[k % 4]), "rw");
        end
        ps_access(1'b1, 8'h3f, $urandom);
        rd_chk(8'h3f, 32'h0, "unmapped");
        w = $urandom;
        ps_access(1'b1, `TSCR_REG_VECTOR_BASE, w);
        repeat (4) begin
            event_valid_in <= 1'b1;
            event_vector_in <= 16'($urandom);
            cyc(1);
            check("handler", {w[31:18], 2'h0, event_vector_in}, handler_addr_out);
            check("handler valid", 32'h1, {31'h0, handler_valid_out});
            event_valid_in <= 1'b0;
            cyc(1);
        end
        w = $urandom & 32'h7fffffff;
        otp_security_word_in <= w;
        otp_load_valid_in <= 1'b1;
        cyc(1);
        otp_load_valid_in <= 1'b0;
        rd_chk(`TSCR_REG_SECURITY, w & `TSCR_SEC_WMASK, "otp copy");
        w = $urandom | 32'h80000000;
        ps_access(1'b1, `TSCR_REG_SECURITY, w);
        ps_access(1'b1, `TSCR_REG_SECURITY, ~w);
        rd_chk(`TSCR_REG_SECURITY, w & `TSCR_SEC_WMASK, "locked");
        for (int k = 0; k < 8; k++) begin
            ps_access(1'b1, `TSCR_REG_TILE_CTRL, 32'(k[1:0]) << 4);
            all_threads_paused_in <= k[2];
            cyc(2);
            check("lp div", k[0] && (!k[1] || k[2]), lp_divider_active_out);
        end
        for (int k = 0; k < 3; k++) begin
            d = k ? 2 + $urandom % 8 : 2;
            dl = k ? $urandom % d : d - 1;
            tx_check();
        end
        ps_access(1'b1, `TSCR_REG_OSC_CTRL, 32'h2);
        ticks(3);
        ps_access(1'b1, `TSCR_REG_OSC_CTRL, 32'h1);
        cyc(10);
        rd_chk(`TSCR_REG_OSC_COUNT0, 32'h3, "count first");
        base = rd_data_out;
        ticks(3);
        rd_chk(`TSCR_REG_OSC_COUNT0, base, "count held");
        ps_access(1'b1, `TSCR_REG_OSC_CTRL, 32'h2);
        ticks(5);
        ps_access(1'b1, `TSCR_REG_OSC_CTRL, 32'h0);
        cyc(10);
        base[15:0] = base[15:0] + 16'h5;
        rd_chk(`TSCR_REG_OSC_COUNT0, base, "count run");
        rst_in <= 1'b1;
        cyc(2);
        rst_in <= 1'b0;
        cyc(6);
        rd_chk(`TSCR_REG_OSC_COUNT0, base, "count kept");
        check("core counts", {base[15:0], base[15:0]}, oscillator_count_value_out[1:0]);
        check("periph counts", {16'h3, 16'h3}, oscillator_count_value_out[3:2]);
        conclude();
    end
endmodule
